// File: core/rpc_config.sv
module rpc_config
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire rpc_pkg::rpc_spi_in_t spi_in,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic [63:0] internal_signals,
  output rpc_pkg::rpc_pins_t pins,
  output logic pin_drive_strength,
  output logic temp_sensor_enable,
  input wire rpc_pkg::rpc_fill_t fill,
  output logic tx_threshold_reached,
  output logic rx_threshold_reached,
  output logic [15:0] sync_word
);
  import rpc_pkg::*;

  // Gray order idle, header, data, done: one bit flips per step
  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_HEADER = 2'b01,
    PHASE_DATA = 2'b11,
    PHASE_DONE = 2'b10
  } rpc_phase_t;

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] csn_sync;
    logic [1:0] si_sync;
    logic [2:0] bit_count;
    rpc_phase_t phase;
    logic is_read;
    logic is_burst;
    logic [5:0] addr;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic so;
    logic so_oe;
    logic tx_hit;
    logic rx_hit;
    logic [NUM_REGS-1:0][7:0] regs;
  } rpc_state_t;

  rpc_state_t state;
  rpc_state_t next_state;

  logic sclk_rise;
  logic sclk_fall;
  logic csn_active;
  logic [7:0] byte_in;
  logic [5:0] next_addr;
  logic [3:0] queue_fill_threshold;
  logic [6:0] tx_threshold;
  logic [6:0] rx_threshold;

  function automatic logic [7:0] read_reg(input rpc_state_t s, input logic [5:0] a);
    // Unmapped addresses read zero instead of aliasing onto the six registers
    read_reg = 8'h00;
    if (a <= ADDR_LAST)
    begin
      read_reg = s.regs[a[2:0]];
    end
  endfunction

  function automatic logic [7:0] write_value(input logic [5:0] a, input logic [7:0] d);
    // Top bit of the pin two register is reserved and always reads zero
    write_value = d;
    if (a == ADDR_PIN2)
    begin
      write_value = d & PIN2_WRITE_MASK;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial edges, all taken from second-stage or later flops
  // Stage three only feeds the edge compare, so si and sclk stay aligned

  assign sclk_rise = state.sclk_sync[1] & ~state.sclk_sync[2];
  assign sclk_fall = ~state.sclk_sync[1] & state.sclk_sync[2];
  assign csn_active = ~state.csn_sync[1];
  assign byte_in = {state.shift_in[6:0], state.si_sync[1]};
  assign next_addr = state.is_burst ? 6'(state.addr + 6'h01) : state.addr; // [R14]

  ////////////////////////////////////////////////////////////////////////////
  // Thresholds
  // Both bounds follow one four-bit setting; upper bits are stored only

  assign queue_fill_threshold = state.regs[ADDR_THRESHOLD][3:0];
  assign tx_threshold = 7'(TX_THRESHOLD_BASE - {1'b0, queue_fill_threshold, 2'b00}); // [R10]
  assign rx_threshold = {({1'b0, queue_fill_threshold} + RX_THRESHOLD_STEP), 2'b00}; // [R10]

  always_comb
  begin
    next_state = state;
    next_state.sclk_sync = {state.sclk_sync[1:0], spi_in.sclk};
    next_state.csn_sync = {state.csn_sync[0], spi_in.csn_n};
    next_state.si_sync = {state.si_sync[0], spi_in.si};
    // Flags registered so a new setting and a new count settle together
    next_state.tx_hit = (fill.tx_bytes >= tx_threshold); // [R9]
    next_state.rx_hit = (fill.rx_bytes >= rx_threshold); // [R9]

    if (!csn_active)
    begin
      // Deselect aborts any partial byte; registers stay untouched
      next_state.phase = PHASE_IDLE;
      next_state.bit_count = 3'h0;
      next_state.shift_out = 8'h00;
      next_state.so = 1'b0;
      next_state.so_oe = 1'b0;
    end
    else
    begin
      next_state.so_oe = 1'b1;
      if (state.phase == PHASE_IDLE)
      begin
        next_state.phase = PHASE_HEADER;
      end
      if (sclk_rise)
      begin
        next_state.shift_in = byte_in;
        next_state.bit_count = 3'(state.bit_count + 3'h1);
      end
      if (sclk_rise && state.bit_count == 3'h7)
      begin
        unique case (state.phase)
          PHASE_IDLE,
          PHASE_HEADER:
          begin
            next_state.phase = PHASE_DATA;
            next_state.is_read = byte_in[BIT_READ];
            next_state.is_burst = byte_in[BIT_BURST]; // [R14]
            next_state.addr = byte_in[5:0];
            if (byte_in[BIT_READ])
            begin
              next_state.shift_out = read_reg(state, byte_in[5:0]);
            end
          end
          PHASE_DATA:
          begin
            // Single access stops after one byte; burst walks addresses
            next_state.phase = state.is_burst ? PHASE_DATA : PHASE_DONE; // [R14]
            next_state.addr = next_addr;
            if (!state.is_read && state.addr <= ADDR_LAST) // [R1] [R5] [R6] [R10] [R11] [R12]
            begin
              next_state.regs[state.addr[2:0]] = write_value(state.addr, byte_in);
            end
            if (state.is_read)
            begin
              next_state.shift_out = state.is_burst ? read_reg(state, next_addr) : 8'h00;
            end
          end
          PHASE_DONE:
          begin
            // Extra bytes of a single access are clocked in and dropped
            next_state.phase = PHASE_DONE;
          end
        endcase
      end
      if (sclk_fall)
      begin
        next_state.so = state.shift_out[7];
        next_state.shift_out = {state.shift_out[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // No sleep input exists: contents only change by reset or host writes

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.sclk_sync <= 3'h0;
      state.csn_sync <= 2'h3;
      state.phase <= PHASE_IDLE;
      state.regs[ADDR_PIN2] <= RESET_PIN2; // [R2]
      state.regs[ADDR_PIN1] <= RESET_PIN1; // [R3] [R5]
      state.regs[ADDR_PIN0] <= RESET_PIN0; // [R4] [R6]
      state.regs[ADDR_THRESHOLD] <= RESET_THRESHOLD; // [R10]
      state.regs[ADDR_SYNC_HIGH] <= RESET_SYNC_HIGH; // [R11]
      state.regs[ADDR_SYNC_LOW] <= RESET_SYNC_LOW; // [R12]
    end
    else
    begin
      state <= next_state; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins, index 0..2 maps to registers at 2..0

  genvar gi;
  generate
    // Each stage registers its pin, so pin outputs come straight from flops
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      rpc_pin_stage u_stage
      (
        .mclk(mclk),
        .reset_n(reset_n),
        .select(state.regs[ADDR_PIN0 - 6'(gi)][5:0]),
        .invert(state.regs[ADDR_PIN0 - 6'(gi)][BIT_INVERT]), // [R1]
        .signals(internal_signals),
        .pin_out(pins.out[gi]),
        .pin_oe(pins.oe[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Port outputs

  assign spi_so = state.so;
  assign spi_so_oe = state.so_oe;
  assign pin_drive_strength = state.regs[ADDR_PIN1][BIT_DRIVE]; // [R5]
  assign temp_sensor_enable = state.regs[ADDR_PIN0][BIT_TEMP]; // [R6]
  assign tx_threshold_reached = state.tx_hit;
  assign rx_threshold_reached = state.rx_hit;
  assign sync_word = {state.regs[ADDR_SYNC_HIGH], state.regs[ADDR_SYNC_LOW]}; // [R11] [R12]

endmodule

// File: core/rpc_pkg.sv
// What this block does
// R1: Bit 6 of each pin register inverts pin
// R2: Pin two select resets to 0x29
// R3: Pin one select resets to 0x2E
// R4: Pin zero select resets to 0x3F
// R5: Pin one bit 7 sets drive strength
// R6: Pin zero bit 7 enables temperature sensor
// R7: Host parks pins two, zero high-impedance
// R8: Host writes zero to reserved threshold bits
// R9: Threshold reached when count at least threshold
// R10: One setting N gives both thresholds
// R11: Sync word high byte resets to 0xD3
// R12: Sync word low byte resets to 0x91
// R13: Registers keep contents through sleep
// R14: Serial port access, burst across addresses
// R15: Invert after select, never on high-impedance
package rpc_pkg;

  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned NUM_PINS = 3;

  localparam logic [5:0] ADDR_PIN2 = 6'h00;
  localparam logic [5:0] ADDR_PIN1 = 6'h01;
  localparam logic [5:0] ADDR_PIN0 = 6'h02;
  localparam logic [5:0] ADDR_THRESHOLD = 6'h03;
  localparam logic [5:0] ADDR_SYNC_HIGH = 6'h04;
  localparam logic [5:0] ADDR_SYNC_LOW = 6'h05;
  localparam logic [5:0] ADDR_LAST = 6'h05;

  localparam logic [7:0] RESET_PIN2 = 8'h29;
  localparam logic [7:0] RESET_PIN1 = 8'h2E;
  localparam logic [7:0] RESET_PIN0 = 8'h3F;
  localparam logic [7:0] RESET_THRESHOLD = 8'h07;
  localparam logic [7:0] RESET_SYNC_HIGH = 8'hD3;
  localparam logic [7:0] RESET_SYNC_LOW = 8'h91;

  localparam int unsigned BIT_INVERT = 6;
  localparam int unsigned BIT_DRIVE = 7;
  localparam int unsigned BIT_TEMP = 7;
  localparam int unsigned BIT_READ = 7;
  localparam int unsigned BIT_BURST = 6;
  localparam logic [7:0] PIN2_WRITE_MASK = 8'h7F;

  localparam logic [5:0] SEL_HIGH_Z = 6'h2E;
  localparam logic [6:0] TX_THRESHOLD_BASE = 7'h3D;
  localparam logic [4:0] RX_THRESHOLD_STEP = 5'h01;

  typedef struct packed {
    logic sclk;
    logic csn_n;
    logic si;
  } rpc_spi_in_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } rpc_pins_t;

  typedef struct packed {
    logic [6:0] tx_bytes;
    logic [6:0] rx_bytes;
  } rpc_fill_t;

endpackage

// File: core/rpc_pin_stage.sv
module rpc_pin_stage
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [5:0] select,
  input wire logic invert,
  input wire logic [63:0] signals,
  output logic pin_out,
  output logic pin_oe
);
  import rpc_pkg::*;

  typedef struct packed {
    logic out;
    logic oe;
  } rpc_pin_state_t;

  rpc_pin_state_t state;
  rpc_pin_state_t next_state;

  always_comb
  begin
    next_state.oe = (select != SEL_HIGH_Z); // [R15]
    // Parked pin drives low internally so nothing toggles behind a disabled driver
    next_state.out = next_state.oe ? (signals[select] ^ invert) : 1'b0; // [R1] [R15]
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign pin_out = state.out;
  assign pin_oe = state.oe;

endmodule

// File: dv/rpc_config_monitor.sv
module rpc_config_monitor
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic spi_so_oe,
  input wire rpc_pkg::rpc_pins_t pins,
  input wire logic pin_drive_strength,
  input wire rpc_pkg::rpc_fill_t fill,
  input wire logic tx_threshold_reached,
  input wire logic rx_threshold_reached,
  input wire logic [15:0] sync_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import rpc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  rx_full_a: assert property (fill.rx_bytes >= 7'h40 |=> rx_threshold_reached)
    else $error("rx flag low");
  rx_low_a: assert property (fill.rx_bytes < 7'h04 |=> !rx_threshold_reached)
    else $error("rx flag high");
  tx_full_a: assert property (fill.tx_bytes >= 7'h3D |=> tx_threshold_reached)
    else $error("tx flag low");
  tx_none_a: assert property (fill.tx_bytes == 7'h00 |=> !tx_threshold_reached)
    else $error("tx flag high");
  // Shared setting: the two bounds always sum to 65
  one_set_a: assert property ({1'b0, fill.rx_bytes} + fill.tx_bytes > 8'h40
    |=> tx_threshold_reached || rx_threshold_reached) else $error("both flags low");
  reset_vals_a: assert property ($rose(reset_n) |=> pins.oe == 3'b101
    && sync_word == 16'hD391 && !pin_drive_strength) else $error("bad reset state");
  park_out_a: assert property ((pins.out & ~pins.oe) == 3'b000)
    else $error("parked pin driven");
  hold_regs_a: assert property (!spi_so_oe && !$past(spi_so_oe) |-> $stable(sync_word))
    else $error("sync word moved");
  cover property (tx_threshold_reached && rx_threshold_reached);
  cover property (pins.oe == 3'b000);
  cover property ($fell(spi_so_oe));
endmodule
////////////////////////////////////////
bind rpc_config rpc_config_monitor mon_u (.*);

// File: dv/rpc_host.sv
module rpc_host
(
  input wire logic mclk,
  input wire logic spi_so,
  output rpc_pkg::rpc_spi_in_t spi
);
  timeunit 1ns;
  timeprecision 1ns;
  import rpc_pkg::*;
  initial spi = 3'b010;
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask
  // Header then n bytes MSB first; device steps the address only when header bit 6 (burst) is set
  task automatic xfer(input logic [7:0] hdr, input logic [63:0] wr, input int n,
    output logic [63:0] rd);
    logic [71:0] sh;
    sh = {hdr, wr};
    rd = '0;
    spi.csn_n = 1'b0;
    half();
    for (int i = 0; i < 8 * n + 8; i++)
    begin
      spi.si = sh[71 - i];
      half();
      spi.sclk = 1'b1;
      rd = {rd[62:0], spi_so};
      half();
      spi.sclk = 1'b0;
    end
    half();
    spi.csn_n = 1'b1;
    // Flip idle data so a stale bit cannot pass
    spi.si = ~spi.si;
    half();
  endtask
endmodule

// File: dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rpc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [63:0] sigs = 64'h0;
  rpc_fill_t fill = '0;
  rpc_spi_in_t spi;
  rpc_pins_t pins;
  logic so, oe, ds, temp, txr, rxr;
  logic [15:0] sync;
  logic [63:0] rd, seen, wv, q[$];
  logic [7:0] b;
  int fails = 0, n_checks = 0, cyc = 0;
  event got;
  always #10 mclk = ~mclk;
  rpc_host host_u (.mclk(mclk), .spi_so(so), .spi(spi));
  rpc_config dut_u (.mclk(mclk), .reset_n(reset_n), .spi_in(spi), .spi_so(so), .spi_so_oe(oe),
    .internal_signals(sigs), .pins(pins), .pin_drive_strength(ds), .temp_sensor_enable(temp),
    .fill(fill), .tx_threshold_reached(txr), .rx_threshold_reached(rxr), .sync_word(sync));
  task automatic chk(input logic [63:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic note(input logic [63:0] g, e);
    q.push_back(e);
    seen = g;
    ->got;
    @(negedge mclk);
  endtask
  always @(got)
    chk(seen, q.pop_front());
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk)
    if (++cyc == 20000)
    begin
      fails++;
      close_out();
    end
  initial
  begin
    void'($urandom(32'hAE0AA583));
    sigs = {$urandom, $urandom};
    wv = {$urandom, $urandom} & 64'hFFFF7F0FFFFF0000;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    repeat (8) @(negedge mclk);
    note(64'(pins),
      64'({sigs[RESET_PIN2[5:0]], 1'b0, sigs[RESET_PIN0[5:0]], 3'b101}));
    host_u.xfer(8'hC0, '0, 8, rd);
    note(rd, 64'h292E3F07D3910000);
    host_u.xfer(8'h40, wv, 6, rd);
    host_u.xfer(8'hC0, '0, 6, rd);
    note(rd, {16'h0, wv[63:16] & 48'h7FFFFFFFFFFF});
    note(64'({ds, sync}), 64'({wv[55], wv[31:16]}));
    for (int p = 0; p < 3; p++)
    begin
      b = wv[63 - 8 * p -: 8];
      note(64'({pins.oe[2 - p], pins.out[2 - p]}),
        64'(b[5:0] == SEL_HIGH_Z ? 2'b00 : {1'b1, sigs[b[5:0]] ^ b[6]}));
    end
    for (int k = 0; k < 2; k++)
    begin
      fill.tx_bytes = 7'(61 - 4 * wv[35:32] - 1 + k);
      fill.rx_bytes = 7'(4 * wv[35:32] + 3 + k);
      repeat (2) @(negedge mclk);
      note(64'({txr, rxr}), k ? 64'h3 : 64'h0);
    end
    host_u.xfer(8'h83, '0, 2, rd);
    note(rd, {40'h0, wv[39:32], 8'h00});
    note(64'(oe), 64'h0);
    fill = {7'h3D, 7'h40};
    host_u.xfer(8'h06, '1, 1, rd);
    host_u.xfer(8'h04, 64'hA55A << 48, 2, rd);
    host_u.xfer(8'hC4, '0, 3, rd);
    note(rd, {40'h0, 8'hA5, wv[23:16], 8'h00});
    host_u.xfer(8'h02, {8'h80, 56'h0}, 1, rd); // Sensor on, all else zero
    note(64'(temp), 64'h1);
    host_u.xfer(8'h40, {24'h2E2E2E, 40'h0}, 3, rd); // Park pins before power-down
    note(64'(pins), 64'h0);
    close_out();
  end
endmodule
